//--- src/ncp_port.sv
// Processor-side numeric coprocessor port with identity value
`timescale 1ns/1ps
`include "ncp_map.svh"
module ncp_port
  import ncp_pkg::*;
#(
  parameter logic [7:0] COMP_ID = `NCP_COMP_ID_DEFAULT, // Arbitrary value
  parameter logic [7:0] REV_ID  = `NCP_REV_ID_DEFAULT
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Coprocessor status pins, active low busy and error
  input  wire logic        busy_n,
  input  wire logic        error_n,
  input  wire logic        operand_request,
  // Interrupt inputs that break the wait stall
  input  wire logic        nonmaskable_interrupt,
  input  wire logic        maskable_interrupt_request,
  input  wire logic        int_enable,
  // Instruction side
  input  wire logic        esc_start,
  input  wire logic [31:0] esc_opcode,
  input  wire logic        wait_start,
  input  wire logic [31:0] operand_wdata,
  output logic             esc_ready,
  output logic             wait_done,
  output logic             fault_valid,
  output logic [7:0]       fault_vector,
  output logic             protocol_32,
  output logic [15:0]      identity_holding_register,
  // I/O bus cycle request
  output logic             io_req,
  output logic [31:0]      io_addr,
  output logic [31:0]      io_wdata,
  output logic             address_bit_two,
  input  wire logic        io_ack
);
  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [2:0] pins_sync;
  ncp_sync #(.WIDTH(3)) u_sync
  (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({busy_n, error_n, operand_request}),
    .sync_out (pins_sync)
  );
  wire busy_act  = ~pins_sync[2];
  wire error_act = ~pins_sync[1];
  wire oprq_act  = pins_sync[0];
  // Interrupts already on our clock, no sync needed
  wire int_break = nonmaskable_interrupt | (maskable_interrupt_request & int_enable);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ncp_state_t  state_ff,  nxt_state;
  logic [3:0]  strap_ff,  nxt_strap;
  logic        proto_ff,  nxt_proto;
  logic        fault_ff,  nxt_fault;
  logic        done_ff,   nxt_done;
  logic [31:0] addr_ff,   nxt_addr;
  logic [31:0] wdata_ff,  nxt_wdata;
  logic [15:0] ident_ff,  nxt_ident;

  // Coprocessor idle and error free: may take a new opcode
  wire cp_can_accept = ~busy_act & ~error_act;
  wire in_idle       = (state_ff == NCP_ST_IDLE);
  wire cycle_active  = (state_ff == NCP_ST_OPCODE) | (state_ff == NCP_ST_OPERAND);
  // Error seen once busy is low ends the wait with a fault
  wire wait_fault    = ~busy_act & error_act;

  // Next-state decode
  always_comb
  begin
    nxt_state = state_ff;
    nxt_strap = strap_ff;
    nxt_proto = proto_ff;
    nxt_fault = 1'b0;
    nxt_done  = 1'b0;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_ident = ident_ff;
    case (state_ff)
      NCP_ST_STRAP:
      begin
        // Let pins settle through the synchroniser before sampling
        nxt_ident = {COMP_ID, REV_ID};
        if (strap_ff != `NCP_STRAP_DELAY)
          nxt_strap = strap_ff + 4'h1;
        else
        begin
          nxt_proto = error_act & ~busy_act;
          nxt_state = NCP_ST_IDLE;
        end
      end
      NCP_ST_IDLE:
      begin
        if (oprq_act)
        begin
          nxt_addr  = `NCP_OPERAND_PORT_ADDR;
          nxt_wdata = operand_wdata;
          nxt_state = NCP_ST_OPERAND;
        end
        else if (esc_start && cp_can_accept)
        begin
          nxt_addr  = `NCP_OPCODE_PORT_ADDR;
          nxt_wdata = esc_opcode;
          nxt_state = NCP_ST_OPCODE;
        end
        else if (wait_start)
          nxt_state = NCP_ST_WAIT;
      end
      NCP_ST_OPCODE, NCP_ST_OPERAND:
      begin
        if (io_ack)
          nxt_state = NCP_ST_IDLE;
      end
      NCP_ST_WAIT:
      begin
        if (!busy_act)
        begin
          nxt_fault = wait_fault;
          nxt_done  = 1'b1;
          nxt_state = NCP_ST_IDLE;
        end
        else if (int_break)
          nxt_state = NCP_ST_IDLE;
      end
      default:
        nxt_state = NCP_ST_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= NCP_ST_STRAP;
      strap_ff <= 4'h0;
      proto_ff <= 1'b0;
      fault_ff <= 1'b0;
      done_ff  <= 1'b0;
      addr_ff  <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      ident_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      strap_ff <= nxt_strap;
      proto_ff <= nxt_proto;
      fault_ff <= nxt_fault;
      done_ff  <= nxt_done;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      ident_ff <= nxt_ident;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign esc_ready    = in_idle & cp_can_accept & ~oprq_act;
  assign wait_done    = done_ff;
  assign fault_valid  = fault_ff;
  assign fault_vector = fault_ff ? `NCP_FAULT_VECTOR : 8'h00;
  assign protocol_32  = proto_ff;
  assign identity_holding_register = ident_ff;
  assign io_req       = cycle_active;
  assign io_addr      = addr_ff;
  assign io_wdata     = wdata_ff;
  // Coprocessor command select is tied to this bit on the board
  assign address_bit_two = addr_ff[`NCP_ADDR_BIT_TWO];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_ident_value: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff != NCP_ST_STRAP) |-> identity_holding_register == {COMP_ID, REV_ID})
    else $error("identity value wrong");
  chk_rev_param: assert property (@(posedge ref_clk) disable iff (!reset_n)
    in_idle |-> identity_holding_register[7:0] == REV_ID)
    else $error("revision byte wrong");
  chk_opcode_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (in_idle && esc_start && cp_can_accept && !oprq_act) |=> state_ff == NCP_ST_OPCODE)
    else $error("opcode not issued at once");
  chk_port_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
    io_req |-> (io_addr == `NCP_OPCODE_PORT_ADDR || io_addr == `NCP_OPERAND_PORT_ADDR))
    else $error("bad coprocessor port address");
  chk_above_pio: assert property (@(posedge ref_clk) disable iff (!reset_n)
    io_req |-> io_addr > `NCP_PIO_LIMIT)
    else $error("port inside programmed I/O range");
  chk_cmd_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == NCP_ST_OPCODE) |-> !address_bit_two)
    else $error("opcode cycle with bit two set");
  chk_wait_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == NCP_ST_WAIT && busy_act && !int_break) |=> state_ff == NCP_ST_WAIT)
    else $error("wait left while busy");
  chk_wait_fault: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == NCP_ST_WAIT && !busy_act) |=> (wait_done && fault_valid == $past(error_act)))
    else $error("wait fault mismatch");
  chk_strap_sample: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_ff == NCP_ST_STRAP && nxt_state == NCP_ST_IDLE) |=>
      protocol_32 == $past(error_act & ~busy_act))
    else $error("protocol strap wrong");
  chk_operand_move: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (in_idle && oprq_act) |=> (state_ff == NCP_ST_OPERAND && address_bit_two))
    else $error("operand request not served");
endmodule : ncp_port

//--- src/ncp_map.svh
// Constants for the numeric coprocessor port block
`ifndef NCP_MAP_SVH
`define NCP_MAP_SVH
`define NCP_OPCODE_PORT_ADDR  32'h8000_00F8
`define NCP_OPERAND_PORT_ADDR 32'h8000_00FC
`define NCP_PIO_LIMIT         32'h0000_FFFF
`define NCP_ADDR_BIT_TWO      2
`define NCP_FAULT_VECTOR      8'h10
`define NCP_COMP_ID_DEFAULT   8'h5A
`define NCP_REV_ID_DEFAULT    8'h00
`define NCP_ID_HI_MSB         15
`define NCP_ID_HI_LSB         8
`define NCP_ID_LO_MSB         7
`define NCP_ID_LO_LSB         0
`define NCP_STRAP_DELAY       4'h4
`endif

//--- src/ncp_pkg.sv
// Types for the numeric coprocessor port block
package ncp_pkg;
  typedef enum logic [2:0] {
    NCP_ST_STRAP,
    NCP_ST_IDLE,
    NCP_ST_OPCODE,
    NCP_ST_OPERAND,
    NCP_ST_WAIT
  } ncp_state_t;
endpackage : ncp_pkg

//--- src/ncp_sync.sv
// Two-flop synchroniser for the coprocessor status pins
`timescale 1ns/1ps
`include "ncp_map.svh"
module ncp_sync
#(
  parameter int WIDTH = 3
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Pin side
  input  wire logic [WIDTH-1:0] async_in,
  // Clock domain side
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Refuse an empty bus at elaboration, not at run time
  if (WIDTH < 1)
  begin : g_bad_width
    $error("ncp_sync: WIDTH must be at least 1");
  end

  // First stage only feeds second stage
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : ncp_sync

//--- verif/ncp_copro_model.sv
// Behavioural coprocessor model on the far side of the port
`timescale 1ns/1ps
module ncp_copro_model
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Controls from the bench
  input  wire logic       set_busy,
  input  wire logic       set_error,
  input  wire logic       op_need,
  input  wire logic [1:0] ack_delay,
  // Pins toward the processor
  input  wire logic       io_req,
  input  wire logic       address_bit_two,
  output logic            io_ack,
  output logic            busy_n,
  output logic            error_n,
  output logic            operand_request,
  output logic            command_select_n
);
  logic [1:0] wait_cnt_ff;

  // ----------------------------------------
  // Static pins
  // ----------------------------------------
  // Select pin wired straight from the address bit
  assign command_select_n = address_bit_two;
  assign busy_n           = !set_busy;
  assign error_n          = !set_error;

  // ----------------------------------------
  // Cycle acknowledge and operand request
  // ----------------------------------------
  // Request drops at first sight of the operand cycle, so sync lag cannot ask twice unless ack_delay is 0
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      io_ack          <= 1'b0;
      wait_cnt_ff     <= 2'h0;
      operand_request <= 1'b0;
    end
    else
    begin
      io_ack      <= io_req && !io_ack && (wait_cnt_ff >= ack_delay);
      wait_cnt_ff <= (io_req && !io_ack) ? wait_cnt_ff + 2'h1 : 2'h0;
      if (op_need)
        operand_request <= 1'b1;
      else if (io_req && command_select_n)
        operand_request <= 1'b0;
    end
  end
endmodule : ncp_copro_model

//--- verif/test_numeric_coprocessor_port.sv
// Self-checking bench for the numeric coprocessor port
`timescale 1ns/1ps
module test_numeric_coprocessor_port;
  localparam logic [7:0] CID = 8'h5A; // Arbitrary value
  localparam logic [7:0] RID = 8'h00;
  logic ref_clk = 1'b0, reset_n = 1'b0, set_busy = 1'b0, set_error = 1'b1, op_need = 1'b0;
  logic nmi = 1'b0, mir = 1'b0, int_en = 1'b0, esc_start = 1'b0, wait_start = 1'b0;
  logic [1:0] ack_delay = 2'h0;
  logic [31:0] esc_opcode = 32'h0000_0000, operand_wdata = 32'h0000_0000;
  logic busy_n, error_n, operand_request, esc_ready, wait_done, fault_valid, protocol_32;
  logic io_req, io_ack, address_bit_two, cmd_sel_n;
  logic [7:0] fault_vector;
  logic [15:0] ident;
  logic [31:0] io_addr, io_wdata;
  int n_mismatch = 0, n_checks = 0;

  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  always #25 ref_clk = ~ref_clk;
  ncp_port #(.COMP_ID(CID), .REV_ID(RID)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .busy_n(busy_n), .error_n(error_n), .operand_request(operand_request),
    .nonmaskable_interrupt(nmi), .maskable_interrupt_request(mir), .int_enable(int_en),
    .esc_start(esc_start), .esc_opcode(esc_opcode), .wait_start(wait_start),
    .operand_wdata(operand_wdata), .esc_ready(esc_ready), .wait_done(wait_done),
    .fault_valid(fault_valid), .fault_vector(fault_vector), .protocol_32(protocol_32),
    .identity_holding_register(ident), .io_req(io_req), .io_addr(io_addr),
    .io_wdata(io_wdata), .address_bit_two(address_bit_two), .io_ack(io_ack));
  ncp_copro_model u_cop (.ref_clk(ref_clk), .reset_n(reset_n), .set_busy(set_busy),
    .set_error(set_error), .op_need(op_need), .ack_delay(ack_delay), .io_req(io_req),
    .address_bit_two(address_bit_two), .io_ack(io_ack), .busy_n(busy_n),
    .error_n(error_n), .operand_request(operand_request), .command_select_n(cmd_sel_n));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Bounded wait on the cycle request; running out ends the run
  task automatic wait_io(input logic lvl);
    for (int i = 0; i < 20 && io_req !== lvl; i++) @(negedge ref_clk);
    if (io_req !== lvl)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : wait_io
  task automatic settle(input logic busy, input logic err);
    set_busy  = busy;
    set_error = err;
    repeat (4) @(negedge ref_clk);
  endtask : settle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Busy or erroring coprocessor must not be handed an opcode
  task automatic t_refuse(input logic busy, input logic err);
    settle(busy, err);
    esc_start = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("refused ready", esc_ready, 1'b0);
    check("refused req", io_req, 1'b0);
    esc_start = 1'b0;
    settle(1'b0, 1'b0);
  endtask : t_refuse
  task automatic t_escape;
    check("ready", esc_ready, 1'b1);
    esc_opcode = 32'h0000_D9E8;
    esc_start  = 1'b1;
    @(negedge ref_clk);
    esc_start = 1'b0;
    check("no preamble", io_req, 1'b1);
    check("op addr", io_addr, 32'h8000_00F8);
    check("op bit2", address_bit_two, 1'b0);
    check("op select", cmd_sel_n, 1'b0);
    check("op data", io_wdata, 32'h0000_D9E8);
    check("above pio", io_addr > 32'h0000_FFFF, 1'b1);
    wait_io(1'b0);
  endtask : t_escape
  task automatic t_operand;
    ack_delay     = 2'h3;
    operand_wdata = 32'h1234_5678;
    op_need       = 1'b1;
    @(negedge ref_clk);
    op_need = 1'b0;
    wait_io(1'b1);
    check("opnd addr", io_addr, 32'h8000_00FC);
    check("cmd select", cmd_sel_n, 1'b1);
    check("opnd data", io_wdata, 32'h1234_5678);
    wait_io(1'b0);
    repeat (6) @(negedge ref_clk);
    check("one word", io_req, 1'b0);
    ack_delay = 2'h0;
  endtask : t_operand
  // Stall then release busy, with or without error
  task automatic t_wait(input logic err);
    settle(1'b1, err);
    wait_start = 1'b1;
    @(negedge ref_clk);
    wait_start = 1'b0;
    repeat (5) @(negedge ref_clk);
    check("stalled", wait_done, 1'b0);
    set_busy = 1'b0;
    for (int i = 0; i < 10 && wait_done !== 1'b1; i++) @(negedge ref_clk);
    check("wait done", wait_done, 1'b1);
    check("fault", fault_valid, err);
    check("vector", fault_vector, err ? 8'h10 : 8'h00);
    settle(1'b0, 1'b0);
  endtask : t_wait
  // Interrupt breaks the stall silently; a masked request does not
  task automatic t_irq(input logic use_nmi, input logic en);
    logic seen;
    seen = 1'b0;
    settle(1'b1, 1'b0);
    wait_start = 1'b1;
    @(negedge ref_clk);
    wait_start = 1'b0;
    repeat (3) @(negedge ref_clk);
    int_en = en;
    nmi    = use_nmi;
    mir    = !use_nmi;
    @(negedge ref_clk);
    nmi = 1'b0;
    mir = 1'b0;
    repeat (3) @(negedge ref_clk);
    set_busy = 1'b0;
    repeat (8)
    begin
      @(negedge ref_clk);
      if (wait_done === 1'b1) seen = 1'b1;
    end
    check("irq break", seen, !use_nmi && !en);
  endtask : t_irq
  // Mid-run reset: outputs clear, strap picks the protocol again
  task automatic t_reset(input logic busy, input logic err, input logic exp_proto);
    set_busy  = busy;
    set_error = err;
    reset_n   = 1'b0;
    @(negedge ref_clk);
    check("rst ident", ident, 16'h0000);
    check("rst ready", esc_ready, 1'b0);
    check("rst req", io_req, 1'b0);
    @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("strap ready", esc_ready, 1'b0);
    repeat (6) @(negedge ref_clk);
    check("rst protocol", protocol_32, exp_proto);
    check("rst identity", ident, {CID, RID});
  endtask : t_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    check("identity", ident, {CID, RID});
    check("protocol", protocol_32, 1'b1);
    settle(1'b0, 1'b0);
    t_refuse(1'b1, 1'b0);
    t_refuse(1'b0, 1'b1);
    t_escape();
    t_operand();
    t_wait(1'b0);
    t_wait(1'b1);
    t_irq(1'b1, 1'b0);
    t_irq(1'b0, 1'b1);
    t_irq(1'b0, 1'b0);
    t_reset(1'b0, 1'b0, 1'b0);
    t_reset(1'b1, 1'b1, 1'b0);
    wrap_up();
  end
endmodule : test_numeric_coprocessor_port
